// >>> rtl/csiu_pkg.sv
/*
  Constants and carrier types for the clock status and interrupt unit.
  Assumes an 8-bit register port on the same clock as the unit.
*/
`default_nettype none

package csiu_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W             = 8;
  localparam int unsigned DATA_W             = 8;
  localparam logic [7:0]  ADDR_IRQ_EN_PLL_IN = 8'h68;
  localparam logic [7:0]  ADDR_IRQ_EN_REF_HO = 8'h69;
  localparam logic [7:0]  ADDR_STICKY_PLL_IN = 8'h6C;
  localparam logic [7:0]  ADDR_LIVE_PLL_IN   = 8'h6D;
  localparam logic [7:0]  ADDR_STICKY_REF_HO = 8'h6E;
  localparam logic [7:0]  ADDR_LIVE_REF_HO   = 8'h6F;

  // ----------------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------------
  localparam int unsigned NUM_INPUTS     = 4;
  localparam int unsigned BIT_VCXO       = 4;  // In the PLL/input group
  localparam int unsigned BIT_SYNTH      = 5;
  localparam int unsigned GRP_A_W        = 6;  // Inputs, VCXO, synth
  localparam int unsigned GRP_B_W        = 2;  // Holdover, reference
  localparam int unsigned NUM_SRC        = GRP_A_W + GRP_B_W;
  localparam logic [7:0]  RST_IRQ_EN     = 8'h00;
  localparam logic [7:0]  RST_PENDING    = 8'h00;
  localparam logic [7:0]  READ_ZERO      = 8'h00;
  localparam logic [1:0]  RST_SYNC_PAD   = 2'h0;

  // ----------------------------------------------------------------------
  // Live condition carrier, all bits from the analog side
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [1:0]            selected_input_live;
    logic                  synth_lock_live;
    logic                  vcxo_lock_live;
    logic [NUM_INPUTS-1:0] input_active_live;
    logic                  synth_calibration_busy;
    logic                  reference_present_live;
    logic                  holdover_live;  // 1 = not in holdover
  } csiu_live_t;

  localparam int unsigned LIVE_W = $bits(csiu_live_t);
  localparam logic [LIVE_W-1:0] RST_LIVE_SYNC = '0;

  // Register port request
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } csiu_req_t;

endpackage : csiu_pkg

`default_nettype wire

// >>> rtl/csiu_top.sv
/*
  Status latching and interrupt gating for a dual-PLL clock conditioner.
  Assumes the register request comes from logic on i_ref_clk and the live
  conditions arrive asynchronously from the analog monitors.
*/
`default_nettype none

// What this block does
// R1: Synth lock-loss flag drives interrupt low only while its enable is 1.
// R2: VCXO lock-loss flag drives interrupt low only while its enable is 1.
// R3: Each input loss-of-signal flag interrupts only while its own enable is 1.
// R4: Reference flag changes interrupt only while reference enable is 1.
// R5: Holdover flag interrupts only while holdover enable is 1.
// R6: Interrupt output is active low.
// R7: Synth sticky reads 0 after any lock loss until cleared.
// R8: Synth sticky reads 1 when no lock loss since last clear.
// R9: Writing 1 clears synth sticky and its pending interrupt.
// R10: Synth sticky is fed by the live synth lock status.
// R11: VCXO sticky reads 0 after lock loss; write 1 clears it.
// R12: Each input sticky reads 0 after signal loss; write 1 clears it.
// R13: Reference sticky reads 0 after reference loss; write 1 clears it.
// R14: Holdover sticky reads 0 after holdover entry; write 1 clears it.
// R15: Interrupt is the OR of all enabled pending flags.
// R16: Live bits ignore writes; sticky bits clear only by write-one.
module csiu_top
  import csiu_pkg::*;
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_sys_rst,
  input  wire csiu_req_t  i_req,
  input  wire csiu_live_t i_live,
  output logic [7:0]      o_reg_rdata,
  output logic            o_rd_valid,
  output logic            o_irq_out_n
);

  // ----------------------------------------------------------------------
  // Live condition synchroniser
  // ----------------------------------------------------------------------
  logic [LIVE_W-1:0] live_meta_q;
  logic [LIVE_W-1:0] live_sync_q;
  csiu_live_t        live;

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      live_meta_q <= RST_LIVE_SYNC;
      live_sync_q <= RST_LIVE_SYNC;
    end else begin
      live_meta_q <= i_live;
      live_sync_q <= live_meta_q;
    end
  end

  assign live = csiu_live_t'(live_sync_q);

  // ----------------------------------------------------------------------
  // Source vector: [3:0] inputs, [4] VCXO, [5] synth, [6] holdover, [7] ref
  // ----------------------------------------------------------------------
  logic [NUM_SRC-1:0] cause;
  logic [NUM_SRC-1:0] clear;
  logic [NUM_SRC-1:0] enable;
  logic [NUM_SRC-1:0] pending_q;
  logic [7:0]         irq_en_a_q;
  logic [7:0]         irq_en_b_q;
  logic               wr_sticky_a;
  logic               wr_sticky_b;

  // Loss is taken as a level: a lasting fault re-arms after a clear
  always_comb begin
    cause[NUM_INPUTS-1:0] = ~live.input_active_live;       // [R12]
    cause[BIT_VCXO]       = ~live.vcxo_lock_live;          // [R11]
    cause[BIT_SYNTH]      = ~live.synth_lock_live;         // [R10]
    cause[GRP_A_W]        = ~live.holdover_live;           // [R14]
    cause[GRP_A_W+1]      = ~live.reference_present_live;  // [R13]
  end

  assign wr_sticky_a = i_req.wr && (i_req.addr == ADDR_STICKY_PLL_IN);
  assign wr_sticky_b = i_req.wr && (i_req.addr == ADDR_STICKY_REF_HO);

  assign clear  = {i_req.wdata[GRP_B_W-1:0] & {GRP_B_W{wr_sticky_b}},
                   i_req.wdata[GRP_A_W-1:0] & {GRP_A_W{wr_sticky_a}}};
  assign enable = {irq_en_b_q[GRP_B_W-1:0], irq_en_a_q[GRP_A_W-1:0]};

  // ----------------------------------------------------------------------
  // Sticky latches, set wins over a clear in the same cycle
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_sticky
      always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
          pending_q[g] <= RST_PENDING[g];
        end else if (cause[g]) begin
          pending_q[g] <= 1'b1;              // [R7] [R11] [R12] [R13] [R14]
        end else if (clear[g]) begin
          pending_q[g] <= 1'b0;              // [R9] [R11] [R12] [R13] [R14]
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Interrupt enables
  // ----------------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      irq_en_a_q <= RST_IRQ_EN;
      irq_en_b_q <= RST_IRQ_EN;
    end else begin
      if (i_req.wr && (i_req.addr == ADDR_IRQ_EN_PLL_IN)) begin
        irq_en_a_q <= {2'h0, i_req.wdata[GRP_A_W-1:0]};
      end
      if (i_req.wr && (i_req.addr == ADDR_IRQ_EN_REF_HO)) begin
        irq_en_b_q <= {6'h00, i_req.wdata[GRP_B_W-1:0]};
      end
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt output, registered so it never glitches at the pin
  // ----------------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_irq_out_n <= 1'b1;
    end else begin
      // [R1] [R2] [R3] [R4] [R5] [R15]
      o_irq_out_n <= ~(|(pending_q & enable));  // [R6]
    end
  end

  // ----------------------------------------------------------------------
  // Read path; sticky bits read inverted, reads have no side effect
  // ----------------------------------------------------------------------
  logic [7:0] rd_mux;

  always_comb begin
    case (i_req.addr)
      ADDR_IRQ_EN_PLL_IN: rd_mux = irq_en_a_q;
      ADDR_IRQ_EN_REF_HO: rd_mux = irq_en_b_q;
      ADDR_STICKY_PLL_IN: rd_mux = {2'h0, ~pending_q[GRP_A_W-1:0]}; // [R8]
      ADDR_LIVE_PLL_IN:   rd_mux = {live.selected_input_live,
                                    live.synth_lock_live,
                                    live.vcxo_lock_live,
                                    live.input_active_live};  // [R16]
      ADDR_STICKY_REF_HO: rd_mux = {6'h00, ~pending_q[NUM_SRC-1:GRP_A_W]};
      ADDR_LIVE_REF_HO:   rd_mux = {5'h00,
                                    live.synth_calibration_busy,
                                    live.reference_present_live,
                                    live.holdover_live};      // [R16]
      default:            rd_mux = READ_ZERO;
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_reg_rdata <= READ_ZERO;
      o_rd_valid  <= 1'b0;
    end else begin
      o_rd_valid <= i_req.rd;
      if (i_req.rd) begin
        o_reg_rdata <= rd_mux;
      end
    end
  end

endmodule // csiu_top

`default_nettype wire

// >>> bench/csiu_cond_model.sv
/* Condition source standing in for the analog monitors.
   Assumes the bench drives i_fault: 1 = condition lost. */
`default_nettype none
module csiu_cond_model
  import csiu_pkg::*;
(
  input  wire logic [10:0] i_fault,
  output wire csiu_live_t  o_live
);
  timeunit 1ns;
  timeprecision 1ps;
  // Lock, activity, reference, holdover are good-high; sel and cal pass raw
  assign #1 o_live = csiu_live_t'(i_fault ^ 11'h1FB);
endmodule // csiu_cond_model
`default_nettype wire

// >>> bench/csiu_monitor.sv
/* Port checker for csiu_top.
   Assumes single clock domain and the register map of csiu_pkg. */
`default_nettype none
module csiu_monitor
  import csiu_pkg::*;
(
  input wire logic       i_ref_clk,
  input wire logic       i_sys_rst,
  input wire csiu_req_t  i_req,
  input wire csiu_live_t i_live,
  input wire logic [7:0] o_reg_rdata,
  input wire logic       o_rd_valid,
  input wire logic       o_irq_out_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  wire logic [7:0] ad = i_req.addr;
  wire logic       rd = i_req.rd && !i_req.wr;
  wire logic       wr = i_req.wr;
  wire logic       sy = i_live.synth_lock_live;
  synth_set_a: assert property (
    (!sy)[*5] ##0 (rd && ad == 8'h6C) |=> !o_reg_rdata[5])
    else $error("synth flag not latched");
  synth_clear_a: assert property (
    sy[*4] ##0 (wr && ad == 8'h6C && i_req.wdata[5]) ##1 (rd && ad == 8'h6C)
    |=> o_reg_rdata[5]) else $error("synth flag not cleared");
  live_read_a: assert property (
    $stable(i_live)[*4] ##0 (rd && ad == 8'h6D)
    |=> o_reg_rdata == $past(i_live[10:3])) else $error("live read wrong");
  unmapped_read_a: assert property (
    i_req.rd && ad == 8'h00 |=> o_rd_valid && o_reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  en_readback_a: assert property (
    wr && ad == 8'h68 ##1 rd && ad == 8'h68
    |=> o_reg_rdata == {2'h0, $past(i_req.wdata[5:0], 2)})
    else $error("enable readback wrong");
  synth_irq_a: assert property (
    (!sy)[*6] ##0 (wr && ad == 8'h68 && i_req.wdata[5]) |=> ##1 !o_irq_out_n)
    else $error("synth interrupt missing");
  hold_irq_a: assert property (
    (!i_live.holdover_live)[*6] ##0 (wr && ad == 8'h69 && i_req.wdata[0])
    |=> ##1 !o_irq_out_n) else $error("holdover interrupt missing");
  irq_off_a: assert property (
    wr && ad == 8'h68 && i_req.wdata == 8'h00 ##1 wr && ad == 8'h69
    && i_req.wdata == 8'h00 |=> ##1 o_irq_out_n) else $error("irq stuck low");
  irq_low_c: cover property (!o_irq_out_n);
  hold_read_c: cover property (rd && ad == 8'h6E);
  irq_clear_c: cover property (!o_irq_out_n ##1 o_irq_out_n);
endmodule // csiu_monitor
bind csiu_top csiu_monitor u_mon (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
  .i_req(i_req), .i_live(i_live), .o_reg_rdata(o_reg_rdata),
  .o_rd_valid(o_rd_valid), .o_irq_out_n(o_irq_out_n));
`default_nettype wire

// >>> bench/clock_status_interrupt_unit_tb.sv
/* Self-checking bench for csiu_top.
   Assumes csiu_cond_model drives the live conditions. */
`default_nettype none
module clock_status_interrupt_unit_tb import csiu_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  csiu_req_t   req = '0;
  logic [10:0] flt = '0;
  csiu_live_t  live;
  logic [7:0]  rdata, m, full, ea, sa;
  logic        rvld, irq_n;
  int          n_mismatch = 0, total_checks = 0;
  always #2 clk = ~clk;
  csiu_cond_model u_cond (.i_fault(flt), .o_live(live));
  csiu_top dut (.i_ref_clk(clk), .i_sys_rst(rst), .i_req(req), .i_live(live),
    .o_reg_rdata(rdata), .o_rd_valid(rvld), .o_irq_out_n(irq_n));
  task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Write is held until the next transfer replaces it, so writes chain
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk) #1 req = '{1'b1, 1'b0, a, d};
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(posedge clk) #1 req = '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk) #1 req = '0;
    chk("rd_valid", 8'h01, {7'h00, rvld});
    chk("rdata", exp, rdata);
  endtask
  task automatic irq(logic e);
    @(posedge clk) #1 req = '0;
    repeat (6) @(posedge clk);
    #1 chk("irq_out_n", {7'h00, e}, {7'h00, irq_n});
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    final_report;
  end
  initial begin
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    irq(1'b1);
    rd(8'h68, 8'h00);
    wr(8'h6C, 8'hFF);
    wr(8'h6E, 8'hFF);
    flt = 11'h404;
    wr(8'h6D, 8'h00);
    irq(1'b1);
    rd(8'h6C, 8'h3F);
    rd(8'h6E, 8'h03);
    rd(8'h6D, 8'hBF);
    rd(8'h6F, 8'h07);
    rd(8'h00, 8'h00);
    for (int k = 0; k < 8; k++) begin
      m = (k < 6) ? 8'h01 << k : 8'h01 << (k - 6);
      full = (k < 6) ? 8'h3F : 8'h03;
      ea = (k < 6) ? 8'h68 : 8'h69;
      sa = (k < 6) ? 8'h6C : 8'h6E;
      flt = (k < 6) ? 11'h008 << k : 11'h001 << (k - 6);
      irq(1'b1);
      wr(ea, m);
      rd(ea, m);
      irq(1'b0);
      flt = '0;
      rd(sa, full ^ m);
      rd(sa, full ^ m);
      irq(1'b0);
      wr(sa, m);
      rd(sa, full);
      irq(1'b1);
      wr(ea, 8'h00);
    end
    flt = 11'h101;
    irq(1'b1);
    wr(8'h68, 8'h20);
    wr(8'h69, 8'h01);
    flt = '0;
    irq(1'b0);
    wr(8'h6C, 8'h20);
    irq(1'b0);
    wr(8'h68, 8'h00);
    wr(8'h69, 8'h00);
    irq(1'b1);
    final_report;
  end
endmodule // clock_status_interrupt_unit_tb
`default_nettype wire
